// ==== core/mwirq_pkg.sv ====
package mwirq_pkg;
	localparam int          MWIRQ_ADDR_W      = 8;
	localparam logic [7:0]  MWIRQ_OFF_SRX     = 8'h3c;
	localparam logic [7:0]  MWIRQ_OFF_RAW     = 8'h40;
	localparam logic [7:0]  MWIRQ_OFF_MSK     = 8'h44;
	localparam logic [7:0]  MWIRQ_OFF_ENSET   = 8'h48;
	localparam logic [7:0]  MWIRQ_OFF_ENCLR   = 8'h4c;
	localparam logic [7:0]  MWIRQ_OFF_CTRL    = 8'h50;
	localparam logic [7:0]  MWIRQ_OFF_SRSTAT  = 8'h54;
	localparam int          MWIRQ_SRX_W       = 5;
	localparam logic [4:0]  MWIRQ_SRX_RST     = 5'h1f;
	localparam int          MWIRQ_BIT_TO      = 0;
	localparam int          MWIRQ_BIT_WR      = 2;
	localparam int          MWIRQ_BIT_SRX_GO  = 0;
	localparam int          MWIRQ_BIT_SRX_EN  = 0;
	localparam int          MWIRQ_BIT_SRX_BSY = 0;
	localparam logic [31:0] MWIRQ_ZERO        = 32'h0000_0000;
	typedef enum logic [1:0] {
		MWIRQ_SR_IDLE,
		MWIRQ_SR_HOLD,
		MWIRQ_SR_EXIT
	} mwirq_sr_t;
endpackage

// ==== core/mwirq_top.sv ====
`timescale 1ns/100ps
module mwirq_top
	import mwirq_pkg::*;
#(
	parameter bit HAS_WAIT = 1'b1
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [MWIRQ_ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    async_wait_input,
	input  wire logic                    async_timeout,
	input  wire logic                    sr_exit_event,
	output logic                         sdram_cmd_hold,
	output logic                         cpu_irq_pulse,
	output logic                         irq
);
	import mwirq_pkg::*;

	logic                   wait_s1_reg;
	logic                   wait_s2_reg;
	logic                   wait_d_reg;
	logic                   wait_rise;
	logic [MWIRQ_SRX_W-1:0] sr_exit_delay_reg;
	logic [MWIRQ_SRX_W-1:0] sr_cnt_reg;
	mwirq_sr_t              sr_state_reg;
	logic                   en_to_reg;
	logic                   en_wr_reg;
	logic                   en_srx_reg;
	logic                   raw_timeout_flag_reg;
	logic                   raw_wait_rise_flag_reg;
	logic                   masked_timeout_flag_reg;
	logic                   masked_wait_rise_flag_reg;
	logic                   srx_irq_reg;
	logic                   wr_en;
	logic                   rd_en;
	logic                   clr_to;
	logic                   clr_wr;
	logic                   clr_srx;
	logic                   addr_ok;
	logic [31:0]            rd_mux;
	logic                   to_evt;
	logic                   srx_done;
	logic                   wr_srx;
	logic                   wr_raw;
	logic                   wr_msk;
	logic                   wr_enset;
	logic                   wr_enclr;
	logic                   wr_ctrl;
	logic                   wr_srstat;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;

	// One strobe per register, all qualified by the access phase
	assign wr_srx    = wr_en && (paddr == MWIRQ_OFF_SRX);
	assign wr_raw    = wr_en && (paddr == MWIRQ_OFF_RAW);
	assign wr_msk    = wr_en && (paddr == MWIRQ_OFF_MSK);
	assign wr_enset  = wr_en && (paddr == MWIRQ_OFF_ENSET);
	assign wr_enclr  = wr_en && (paddr == MWIRQ_OFF_ENCLR);
	assign wr_ctrl   = wr_en && (paddr == MWIRQ_OFF_CTRL);
	assign wr_srstat = wr_en && (paddr == MWIRQ_OFF_SRSTAT);

	// Synchroniser; first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_s1_reg <= 1'b0;
			wait_s2_reg <= 1'b0;
			wait_d_reg  <= 1'b0;
		end else begin
			wait_s1_reg <= async_wait_input;
			wait_s2_reg <= wait_s1_reg;
			wait_d_reg  <= wait_s2_reg;
		end
	end

	assign wait_rise = HAS_WAIT & wait_s2_reg & ~wait_d_reg;
	assign to_evt    = HAS_WAIT & async_timeout;

	// Self-refresh exit timing field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_exit_delay_reg <= MWIRQ_SRX_RST;
		end else if (wr_srx) begin
			sr_exit_delay_reg <= pwdata[MWIRQ_SRX_W-1:0];
		end
	end

	// Hold sequencer state; exits seen while holding are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_state_reg <= MWIRQ_SR_IDLE;
		end else begin
			unique case (sr_state_reg)
				MWIRQ_SR_IDLE: begin
					if (sr_exit_event) begin
						sr_state_reg <= MWIRQ_SR_HOLD;
					end
				end
				MWIRQ_SR_HOLD: begin
					if (sr_cnt_reg == '0) begin
						sr_state_reg <= MWIRQ_SR_EXIT;
					end
				end
				MWIRQ_SR_EXIT: begin
					sr_state_reg <= MWIRQ_SR_IDLE;
				end
			endcase
		end
	end

	// Remaining hold cycles, loaded from the field at the exit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_cnt_reg <= '0;
		end else if (sr_state_reg == MWIRQ_SR_IDLE && sr_exit_event) begin
			sr_cnt_reg <= sr_exit_delay_reg;
		end else if (sr_state_reg == MWIRQ_SR_HOLD && sr_cnt_reg != '0) begin
			sr_cnt_reg <= sr_cnt_reg - 1'b1;
		end
	end

	// Command hold: field value plus one cycles after the exit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdram_cmd_hold <= 1'b0;
		end else if (sr_state_reg == MWIRQ_SR_IDLE && sr_exit_event) begin
			sdram_cmd_hold <= 1'b1;
		end else if (sr_state_reg == MWIRQ_SR_HOLD && sr_cnt_reg == '0) begin
			sdram_cmd_hold <= 1'b0;
		end
	end

	assign srx_done = (sr_state_reg == MWIRQ_SR_EXIT);

	// Timeout enable: set and clear controls share one state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_to_reg <= 1'b0;
		end else if (wr_enset && pwdata[MWIRQ_BIT_TO]) begin
			en_to_reg <= 1'b1;
		end else if (wr_enclr && pwdata[MWIRQ_BIT_TO]) begin
			en_to_reg <= 1'b0;
		end
	end

	// Wait-rise enable, same scheme
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_wr_reg <= 1'b0;
		end else if (wr_enset && pwdata[MWIRQ_BIT_WR]) begin
			en_wr_reg <= 1'b1;
		end else if (wr_enclr && pwdata[MWIRQ_BIT_WR]) begin
			en_wr_reg <= 1'b0;
		end
	end

	// Self-refresh-done interrupt enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_srx_reg <= 1'b0;
		end else if (wr_ctrl) begin
			en_srx_reg <= pwdata[MWIRQ_BIT_SRX_EN];
		end
	end

	// Writing one to either view clears both flags of a pair
	assign clr_to  = pwdata[MWIRQ_BIT_TO] && (wr_raw || wr_msk);
	assign clr_wr  = pwdata[MWIRQ_BIT_WR] && (wr_raw || wr_msk);
	assign clr_srx = wr_srstat && pwdata[MWIRQ_BIT_SRX_GO];

	// Status flags; a set beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_timeout_flag_reg <= 1'b0;
		end else if (to_evt) begin
			raw_timeout_flag_reg <= 1'b1;
		end else if (clr_to) begin
			raw_timeout_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			masked_timeout_flag_reg <= 1'b0;
		end else if (to_evt && en_to_reg) begin
			masked_timeout_flag_reg <= 1'b1;
		end else if (clr_to) begin
			masked_timeout_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_wait_rise_flag_reg <= 1'b0;
		end else if (wait_rise) begin
			raw_wait_rise_flag_reg <= 1'b1;
		end else if (clr_wr) begin
			raw_wait_rise_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			masked_wait_rise_flag_reg <= 1'b0;
		end else if (wait_rise && en_wr_reg) begin
			masked_wait_rise_flag_reg <= 1'b1;
		end else if (clr_wr) begin
			masked_wait_rise_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srx_irq_reg <= 1'b0;
		end else if (srx_done) begin
			srx_irq_reg <= 1'b1;
		end else if (clr_srx) begin
			srx_irq_reg <= 1'b0;
		end
	end

	// Pulse on each new masked timeout, one cycle wide
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_irq_pulse <= 1'b0;
		end else begin
			cpu_irq_pulse <= to_evt & en_to_reg & ~masked_timeout_flag_reg;
		end
	end

	// Level interrupt, registered so it lags the flags by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= masked_timeout_flag_reg | masked_wait_rise_flag_reg |
				(srx_irq_reg & en_srx_reg);
		end
	end

	// Read mux; unused bits stay zero
	always_comb begin
		rd_mux  = MWIRQ_ZERO;
		addr_ok = 1'b1;
		unique case (paddr)
			MWIRQ_OFF_SRX: rd_mux[MWIRQ_SRX_W-1:0] = sr_exit_delay_reg;
			MWIRQ_OFF_RAW: begin
				rd_mux[MWIRQ_BIT_TO] = raw_timeout_flag_reg;
				rd_mux[MWIRQ_BIT_WR] = raw_wait_rise_flag_reg;
			end
			MWIRQ_OFF_MSK: begin
				rd_mux[MWIRQ_BIT_TO] = masked_timeout_flag_reg;
				rd_mux[MWIRQ_BIT_WR] = masked_wait_rise_flag_reg;
			end
			MWIRQ_OFF_ENSET, MWIRQ_OFF_ENCLR: begin
				rd_mux[MWIRQ_BIT_TO] = en_to_reg;
				rd_mux[MWIRQ_BIT_WR] = en_wr_reg;
			end
			MWIRQ_OFF_CTRL: rd_mux[MWIRQ_BIT_SRX_EN] = en_srx_reg;
			MWIRQ_OFF_SRSTAT: begin
				rd_mux[MWIRQ_BIT_SRX_GO]      = srx_irq_reg;
				rd_mux[MWIRQ_BIT_SRX_BSY + 1] = sdram_cmd_hold;
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// Read data latched in setup so it stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= MWIRQ_ZERO;
		end else if (rd_en) begin
			prdata <= rd_mux;
		end
	end

	// Ready in every access phase; no register needs a wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel & ~penable;
		end
	end

	// Error only for an unmapped address, alongside ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel & ~penable & ~addr_ok;
		end
	end
endmodule

// ==== sim/mwirq_checker.sv ====
`timescale 1ns/100ps
module mwirq_checker
	import mwirq_pkg::*;
(
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [MWIRQ_ADDR_W-1:0] paddr,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic                    async_timeout,
	input wire logic                    sr_exit_event,
	input wire logic                    sdram_cmd_hold,
	input wire logic                    cpu_irq_pulse,
	input wire logic                    irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_reads_zero: assert property (pslverr && !pwrite |-> pready && prdata == MWIRQ_ZERO)
		else $error("refused read returned data");
	a_srx_upper_zero: assert property (
		pready && !pwrite && paddr == MWIRQ_OFF_SRX |-> prdata[31:5] == 27'h0)
		else $error("exit timing upper bits not zero");
	a_stat_unused_zero: assert property (
		pready && !pwrite && (paddr == MWIRQ_OFF_RAW || paddr == MWIRQ_OFF_MSK)
		|-> prdata[31:3] == 29'h0 && !prdata[1])
		else $error("status unused bits not zero");
	a_pulse_single: assert property (cpu_irq_pulse |=> !cpu_irq_pulse)
		else $error("cpu pulse longer than one cycle");
	a_pulse_cause: assert property (cpu_irq_pulse |-> $past(async_timeout))
		else $error("cpu pulse without timeout");
	a_pulse_then_irq: assert property (cpu_irq_pulse |=> irq)
		else $error("irq level missing after pulse");
	a_hold_window: assert property (
		sr_exit_event |=> sdram_cmd_hold ##[1:32] !sdram_cmd_hold)
		else $error("command hold missing or too long");
endmodule
bind mwirq_top mwirq_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .async_timeout(async_timeout), .sr_exit_event(sr_exit_event),
	.sdram_cmd_hold(sdram_cmd_hold), .cpu_irq_pulse(cpu_irq_pulse), .irq(irq));

// ==== sim/mwirq_far.sv ====
`timescale 1ns/100ps
module mwirq_far (
	input  wire logic pclk,
	input  wire logic cpu_irq_pulse,
	output logic      async_wait_input
);
	int pulses = 0;
	initial async_wait_input = 1'b0;
	// Counts clock edges with the pulse high, so a stretched pulse is counted more than once
	always @(posedge pclk) if (cpu_irq_pulse === 1'b1) pulses++;
	task automatic rise(input int n);
		async_wait_input <= 1'b1;
		repeat (n) @(posedge pclk);
		async_wait_input <= 1'b0;
	endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench;
	import mwirq_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        async_timeout = 1'b0, sr_exit_event = 1'b0, async_wait_input;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, sdram_cmd_hold, cpu_irq_pulse, irq;
	logic [31:0] q[$];
	logic [4:0]  fld;
	int          fails = 0, comparisons = 0, seed = 24316, n;
	mwirq_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .async_wait_input(async_wait_input), .async_timeout(async_timeout),
		.sr_exit_event(sr_exit_event), .sdram_cmd_hold(sdram_cmd_hold),
		.cpu_irq_pulse(cpu_irq_pulse), .irq(irq));
	mwirq_far u_far (.pclk(pclk), .cpu_irq_pulse(cpu_irq_pulse),
		.async_wait_input(async_wait_input));
	initial forever #2 pclk = ~pclk;
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("mismatch %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Idle edge after each transfer keeps psel from being written twice in one step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) chk(32'h0, 32'h1);
		if (k >= 50) print_verdict();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic tmo();
		async_timeout <= 1'b1;
		@(posedge pclk);
		async_timeout <= 1'b0;
		@(posedge pclk);
	endtask
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
			chk(prdata, q.pop_front());
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(MWIRQ_OFF_SRX, {27'h0, MWIRQ_SRX_RST});
		rd(MWIRQ_OFF_RAW, MWIRQ_ZERO);
		rd(8'h80, MWIRQ_ZERO);
		wr(MWIRQ_OFF_SRX, 32'hffff_ffff);
		rd(MWIRQ_OFF_SRX, 32'h0000_001f);
		$display("reset and timing register done");
		repeat (3) begin
			fld = 5'($random(seed));
			wr(MWIRQ_OFF_SRX, {27'h0, fld});
			sr_exit_event <= 1'b1;
			@(posedge pclk);
			sr_exit_event <= 1'b0;
			n = 0;
			repeat (40) begin
				@(posedge pclk);
				if (sdram_cmd_hold === 1'b1) n++;
			end
			chk(32'(n), 32'(fld) + 32'h1);
		end
		$display("self-refresh exit hold done");
		tmo();
		rd(MWIRQ_OFF_RAW, 32'h1);
		rd(MWIRQ_OFF_MSK, MWIRQ_ZERO);
		wr(MWIRQ_OFF_RAW, MWIRQ_ZERO);
		rd(MWIRQ_OFF_RAW, 32'h1);
		wr(MWIRQ_OFF_RAW, 32'h1);
		rd(MWIRQ_OFF_RAW, MWIRQ_ZERO);
		chk({31'h0, irq}, 32'h0);
		wr(MWIRQ_OFF_ENSET, 32'h5);
		rd(MWIRQ_OFF_ENCLR, 32'h5);
		tmo();
		rd(MWIRQ_OFF_MSK, 32'h1);
		chk({31'h0, irq}, 32'h1);
		chk(32'(u_far.pulses), 32'h1);
		wr(MWIRQ_OFF_MSK, 32'h1);
		rd(MWIRQ_OFF_RAW, MWIRQ_ZERO);
		chk({31'h0, irq}, 32'h0);
		$display("timeout flags done");
		for (int i = 0; i < 2; i++) begin
			u_far.rise(3);
			repeat (2) @(posedge pclk);
			rd(MWIRQ_OFF_RAW, 32'h4);
			rd(MWIRQ_OFF_MSK, 32'h4);
			wr(i ? MWIRQ_OFF_MSK : MWIRQ_OFF_RAW, 32'h4);
			rd(i ? MWIRQ_OFF_RAW : MWIRQ_OFF_MSK, MWIRQ_ZERO);
		end
		$display("wait rise flags done");
		wr(MWIRQ_OFF_ENCLR, 32'h5);
		rd(MWIRQ_OFF_ENSET, MWIRQ_ZERO);
		tmo();
		rd(MWIRQ_OFF_MSK, MWIRQ_ZERO);
		chk(32'(u_far.pulses), 32'h1);
		fork
			wr(MWIRQ_OFF_RAW, 32'h1);
			begin
				@(posedge pclk);
				async_timeout <= 1'b1;
				@(posedge pclk);
				async_timeout <= 1'b0;
			end
		join
		rd(MWIRQ_OFF_RAW, 32'h1);
		$display("enable clear done");
		print_verdict();
	end
endmodule
